// >>> pkg/fbm_map.svh
// register offsets, field positions, reset values and counts of the fieldbus master control
// Summary of operation
// - after reset master stays off, indicators dark
// - bus parameters loaded: go online, light indicator
// - valid configuration: enter data exchange, show it
// - new configuration load restarts master from registers
// - controller stop: broadcast clear to all slaves
// - stop: fail-safe slaves get zero-length telegram
// - stop: other slaves get full telegram, zeros
// - stop: keep copying slave inputs into area
// - controller run: broadcast operate to all slaves
// - run: serve each slave with latest outputs
// - run: copy slave inputs into input area
`ifndef FBM_MAP_SVH
`define FBM_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FBM_CFG_OFS 8'h00
`define FBM_STAT_OFS 8'h04
`define FBM_ADDR_OFS 8'h08
`define FBM_NSLV_OFS 8'h0C
`define FBM_FSAFE_OFS 8'h10
`define FBM_OUT_BASE 8'h40
`define FBM_IN_BASE 8'h80
`define FBM_SLOT_MASK 8'hE0
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define FBM_CFG_BUSPAR_BIT 0
`define FBM_CFG_SLVCFG_BIT 1
`define FBM_STAT_RUN_BIT 2
`define FBM_STAT_ON_BIT 3
`define FBM_STAT_DX_BIT 4
`define FBM_ADDR_W 7
`define FBM_CFG_RST 2'h0
`define FBM_ADDR_RST 7'h00
`define FBM_TG_LEN_FULL 8'h04
`define FBM_TG_LEN_ZERO 8'h00
`define FBM_RESP_OKAY 2'h0
`define FBM_RESP_SLVERR 2'h2
`endif

// >>> pkg/fbm_pkg.sv
// types shared by the fieldbus master control modules
`default_nettype none
package fbm_pkg;
  typedef enum logic [1:0] {st_off, st_online, st_gc, st_xchg} fbm_state_t;
  typedef enum logic {gc_clear, gc_operate} fbm_gc_t;
endpackage : fbm_pkg
`default_nettype wire

// >>> pkg/fbm_reg_if.sv
// register access carrier between the bus slave and the master control
`timescale 1ns/1ns
`default_nettype none
interface fbm_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : fbm_reg_if
`default_nettype wire

// >>> src/fbm_axil.sv
// AXI4-Lite slave front end of the fieldbus master control
`timescale 1ns/1ns
`default_nettype none
`include "fbm_map.svh"
module fbm_axil
  import fbm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  fbm_reg_if.bus rif
);
  logic aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire aw_full = aw_have_r || aw_take;
  wire w_full = w_have_r || w_take;
  // address and data may come in either order; the write fires once both are held
  wire do_wr = aw_full && w_full && !bvalid;
  wire aw_have_nxt = aw_full && !do_wr;
  wire w_have_nxt = w_full && !do_wr;
  wire bvalid_nxt = do_wr || (bvalid && !bready);
  wire ar_take = arvalid && arready;
  wire rvalid_nxt = ar_take || (rvalid && !rready);
  assign rif.wr_en = do_wr;
  assign rif.wr_addr = aw_take ? awaddr : aw_addr_r;
  assign rif.wr_data = w_take ? wdata : w_data_r;
  assign rif.wr_strb = w_take ? wstrb : w_strb_r;
  assign rif.rd_addr = araddr;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FBM_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `FBM_RESP_OKAY;
    end
    else if (aclken)
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      if (aw_take) aw_addr_r <= awaddr;
      if (w_take) w_data_r <= wdata;
      if (w_take) w_strb_r <= wstrb;
      awready <= !aw_have_nxt && !bvalid_nxt;
      wready <= !w_have_nxt && !bvalid_nxt;
      bvalid <= bvalid_nxt;
      if (do_wr) bresp <= rif.wr_err ? `FBM_RESP_SLVERR : `FBM_RESP_OKAY;
      arready <= !rvalid_nxt;
      rvalid <= rvalid_nxt;
      if (ar_take) rdata <= rif.rd_err ? 32'h0000_0000 : rif.rd_data;
      if (ar_take) rresp <= rif.rd_err ? `FBM_RESP_SLVERR : `FBM_RESP_OKAY;
    end
  end
endmodule : fbm_axil
`default_nettype wire

// >>> src/fbm_master_ctrl.sv
// run-state control of the fieldbus master: start-up, global control, cyclic exchange
`timescale 1ns/1ns
`default_nettype none
`include "fbm_map.svh"
module fbm_master_ctrl
  import fbm_pkg::*;
#(
  parameter int NSLV = 8,
  parameter int DW = 32
)
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller run state
  input wire logic cpu_run,
  // telegrams toward the slaves
  output logic tg_valid,
  input wire logic tg_ready,
  output logic tg_gc,
  output fbm_gc_t tg_cmd,
  output logic [2:0] tg_slave,
  output logic [7:0] tg_len,
  output logic [DW-1:0] tg_data,
  // input data from the slaves
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [2:0] rx_slave,
  input wire logic [DW-1:0] rx_data,
  // indicators and station address
  output logic master_online_indicator,
  output logic data_exchange_indicator,
  output logic [`FBM_ADDR_W-1:0] station_addr
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // slot indices and counts compare at four bits, enough for eight slaves
  localparam logic [3:0] NSLV_L = 4'(NSLV);

  // one word per slave, slots one word apart in a block of eight words
  function automatic logic slot_hit(input logic [7:0] a, input logic [7:0] base);
    slot_hit = ((a & `FBM_SLOT_MASK) == base) && (a[1:0] == 2'b00)
               && ({1'b0, a[4:2]} < NSLV_L);
  endfunction : slot_hit

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    strb_merge = res;
  endfunction : strb_merge

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  fbm_reg_if rif ();

  fbm_axil fbm_axil_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rif(rif.bus)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  fbm_state_t state_r, state_nxt;
  logic [1:0] cfg_sh_r;
  logic [1:0] cfg_r;
  logic [`FBM_ADDR_W-1:0] addr_sh_r;
  logic [3:0] nslv_sh_r, nslv_r;
  logic [NSLV-1:0] fs_sh_r, fs_r;
  logic [DW-1:0] out_r [NSLV];
  logic [DW-1:0] in_r [NSLV];
  logic run_r, run_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic issue_gc, issue_tg;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire [31:0] wd = rif.wr_data;
  wire [3:0] ws = rif.wr_strb;
  wire wr_cfg = rif.wr_en && (rif.wr_addr == `FBM_CFG_OFS);
  wire wr_addr_reg = rif.wr_en && (rif.wr_addr == `FBM_ADDR_OFS);
  wire wr_nslv = rif.wr_en && (rif.wr_addr == `FBM_NSLV_OFS);
  wire wr_fs = rif.wr_en && (rif.wr_addr == `FBM_FSAFE_OFS);
  wire wr_out = rif.wr_en && slot_hit(rif.wr_addr, `FBM_OUT_BASE);
  wire [2:0] wr_slot = rif.wr_addr[4:2];
  // status is read-only; a write to it is refused
  wire wr_ok = (rif.wr_addr == `FBM_CFG_OFS) || (rif.wr_addr == `FBM_ADDR_OFS)
               || (rif.wr_addr == `FBM_NSLV_OFS) || (rif.wr_addr == `FBM_FSAFE_OFS)
               || slot_hit(rif.wr_addr, `FBM_OUT_BASE);
  assign rif.wr_err = !wr_ok;

  // a write to the configuration word hands the whole set to the master
  wire load = wr_cfg;
  wire [31:0] cfg_new = strb_merge({30'h0, cfg_sh_r}, wd, ws);

  wire [31:0] stat_word = {27'h0, data_exchange_indicator, master_online_indicator,
                           run_r, state_r};
  wire [2:0] rd_slot = rif.rd_addr[4:2];
  wire rd_out = slot_hit(rif.rd_addr, `FBM_OUT_BASE);
  wire rd_in = slot_hit(rif.rd_addr, `FBM_IN_BASE);
  wire [31:0] rd_out_w = 32'(out_r[rd_slot]);
  wire [31:0] rd_in_w = 32'(in_r[rd_slot]);
  // unmapped reads return zero; the bus slave flags them with an error response
  assign rif.rd_data =
    (rif.rd_addr == `FBM_CFG_OFS) ? {30'h0, cfg_sh_r} :
    (rif.rd_addr == `FBM_STAT_OFS) ? stat_word :
    (rif.rd_addr == `FBM_ADDR_OFS) ? {25'h0, addr_sh_r} :
    (rif.rd_addr == `FBM_NSLV_OFS) ? {28'h0, nslv_sh_r} :
    (rif.rd_addr == `FBM_FSAFE_OFS) ? 32'(fs_sh_r) :
    rd_out ? rd_out_w :
    rd_in ? rd_in_w : 32'h0000_0000;
  assign rif.rd_err = !((rif.rd_addr == `FBM_CFG_OFS) || (rif.rd_addr == `FBM_STAT_OFS)
                        || (rif.rd_addr == `FBM_ADDR_OFS) || (rif.rd_addr == `FBM_NSLV_OFS)
                        || (rif.rd_addr == `FBM_FSAFE_OFS) || rd_out || rd_in);

  // ----------------------------------------
  // telegram contents
  // ----------------------------------------
  wire tg_free = !tg_valid || tg_ready;
  wire have_slaves = (nslv_r != 4'h0);
  wire fs_now = fs_r[idx_r];
  // stop: fail-safe slaves get an empty telegram, the rest zeroed outputs
  wire [7:0] len_now = (!run_r && fs_now) ? `FBM_TG_LEN_ZERO : `FBM_TG_LEN_FULL;
  wire [DW-1:0] data_now = run_r ? out_r[idx_r] : '0;
  wire [2:0] idx_wrap = ({1'b0, idx_r} + 4'h1 >= nslv_r) ? 3'h0 : idx_r + 3'h1;
  wire rx_take = rx_valid && rx_ready;
  // words from slaves beyond the active count are dropped, never stored
  wire rx_in_range = ({1'b0, rx_slave} < nslv_r);

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    run_nxt = run_r;
    idx_nxt = idx_r;
    issue_gc = 1'b0;
    issue_tg = 1'b0;
    unique case (state_r)
      st_off:
      begin
        // only a load with the bus parameter bit leaves this state
        state_nxt = st_off;
      end
      st_online:
      begin
        if (cfg_r[`FBM_CFG_SLVCFG_BIT])
          state_nxt = st_gc;
      end
      st_gc:
      begin
        // command goes out before any cyclic telegram of the new state
        if (tg_free)
        begin
          issue_gc = 1'b1;
          run_nxt = cpu_run;
          idx_nxt = 3'h0;
          state_nxt = st_xchg;
        end
      end
      st_xchg:
      begin
        if (cpu_run != run_r)
          state_nxt = st_gc;
        else if (tg_free && have_slaves)
        begin
          issue_tg = 1'b1;
          idx_nxt = idx_wrap;
        end
      end
    endcase
    // a fresh configuration restarts from the loaded parameters
    if (load)
    begin
      state_nxt = cfg_new[`FBM_CFG_BUSPAR_BIT] ? st_online : st_off;
      issue_gc = 1'b0;
      issue_tg = 1'b0;
      idx_nxt = 3'h0;
    end
  end

  // ----------------------------------------
  // control and configuration flops
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= st_off;
      run_r <= 1'b0;
      idx_r <= 3'h0;
      cfg_sh_r <= `FBM_CFG_RST;
      cfg_r <= `FBM_CFG_RST;
      addr_sh_r <= `FBM_ADDR_RST;
      station_addr <= `FBM_ADDR_RST;
      nslv_sh_r <= 4'h0;
      nslv_r <= 4'h0;
      fs_sh_r <= '0;
      fs_r <= '0;
    end
    else if (aclken)
    begin
      state_r <= state_nxt;
      run_r <= run_nxt;
      idx_r <= idx_nxt;
      if (wr_cfg) cfg_sh_r <= cfg_new[1:0];
      if (wr_addr_reg) addr_sh_r <= `FBM_ADDR_W'(strb_merge({25'h0, addr_sh_r}, wd, ws));
      if (wr_nslv) nslv_sh_r <= 4'(strb_merge({28'h0, nslv_sh_r}, wd, ws));
      if (wr_fs) fs_sh_r <= NSLV'(strb_merge(32'(fs_sh_r), wd, ws));
      if (load)
      begin
        cfg_r <= cfg_new[1:0];
        station_addr <= addr_sh_r;
        // counts beyond the slot array are clamped so the round robin stays inside it
        nslv_r <= (nslv_sh_r > NSLV_L) ? NSLV_L : nslv_sh_r;
        fs_r <= fs_sh_r;
      end
    end
  end

  // ----------------------------------------
  // process data areas
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NSLV; i++)
      begin
        out_r[i] <= '0;
        in_r[i] <= '0;
      end
    end
    else if (aclken)
    begin
      if (wr_out) out_r[wr_slot] <= DW'(strb_merge(32'(out_r[wr_slot]), wd, ws));
      // inputs keep flowing in stop as well as in run
      if (rx_take && rx_in_range) in_r[rx_slave] <= rx_data;
    end
  end

  // ----------------------------------------
  // telegram and indicator outputs
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tg_valid <= 1'b0;
      tg_gc <= 1'b0;
      tg_cmd <= gc_clear;
      tg_slave <= 3'h0;
      tg_len <= `FBM_TG_LEN_ZERO;
      tg_data <= '0;
      rx_ready <= 1'b0;
      master_online_indicator <= 1'b0;
      data_exchange_indicator <= 1'b0;
    end
    else if (aclken)
    begin
      // a taken telegram is replaced in the same cycle, so slaves are served back to back
      if (issue_gc || issue_tg)
        tg_valid <= 1'b1;
      else if (tg_ready)
        tg_valid <= 1'b0;
      if (issue_gc)
      begin
        tg_gc <= 1'b1;
        tg_cmd <= cpu_run ? gc_operate : gc_clear;
        tg_slave <= 3'h0;
        tg_len <= `FBM_TG_LEN_ZERO;
        tg_data <= '0;
      end
      else if (issue_tg)
      begin
        tg_gc <= 1'b0;
        tg_slave <= idx_r;
        tg_len <= len_now;
        tg_data <= data_now;
      end
      // slave inputs are only taken while exchanging
      rx_ready <= (state_nxt == st_xchg);
      master_online_indicator <= (state_nxt != st_off);
      data_exchange_indicator <= (state_nxt == st_gc) || (state_nxt == st_xchg);
    end
  end

  // the protection bits carry no meaning for this block
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule : fbm_master_ctrl
`default_nettype wire

// >>> verification/fbm_master_ctrl_monitor.sv
// concurrent checks on telegrams and indicators of the master control
`timescale 1ns/1ns
`default_nettype none
module fbm_master_ctrl_monitor
  import fbm_pkg::*;
#(
  parameter int DW = 32
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // run state and telegrams
  input wire logic cpu_run,
  input wire logic tg_valid,
  input wire logic tg_ready,
  input wire logic tg_gc,
  input wire fbm_gc_t tg_cmd,
  input wire logic [2:0] tg_slave,
  input wire logic [7:0] tg_len,
  input wire logic [DW-1:0] tg_data,
  // indicators
  input wire logic master_online_indicator,
  input wire logic data_exchange_indicator
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the last broadcast taken tells which run state data telegrams serve
  fbm_gc_t last_cmd_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      last_cmd_r <= gc_clear;
    else if (tg_valid && tg_ready && tg_gc)
      last_cmd_r <= tg_cmd;
  end
  property p_dark;
    $past(aresetn) == 1'b0 |-> !master_online_indicator && !data_exchange_indicator;
  endproperty
  a_dark: assert property (p_dark)
    else $error("indicator lit after reset");
  property p_dx_online;
    data_exchange_indicator |-> master_online_indicator;
  endproperty
  a_dx_online: assert property (p_dx_online)
    else $error("exchange without online");
  property p_hold;
    tg_valid && !tg_ready |=> tg_valid && $stable(tg_data) && $stable(tg_len)
      && $stable(tg_slave) && $stable(tg_gc);
  endproperty
  a_hold: assert property (p_hold)
    else $error("telegram changed while pending");
  property p_gc_cmd;
    tg_valid && tg_gc && (!$past(tg_valid) || $past(tg_ready))
      |-> tg_cmd == fbm_gc_t'($past(cpu_run)) && tg_len == 8'h00;
  endproperty
  a_gc_cmd: assert property (p_gc_cmd)
    else $error("broadcast command wrong");
  property p_change;
    $changed(cpu_run) && data_exchange_indicator
      |-> ##[1:40] (tg_valid && tg_ready && tg_gc && tg_cmd == fbm_gc_t'(cpu_run));
  endproperty
  a_change: assert property (p_change)
    else $error("no broadcast after run change");
  property p_empty;
    tg_valid && !tg_gc && tg_len == 8'h00 |-> last_cmd_r == gc_clear && tg_data == '0;
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty telegram outside stop");
  property p_stop_zero;
    tg_valid && !tg_gc && last_cmd_r == gc_clear |-> tg_data == '0;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("stop telegram carries data");
  property p_run_len;
    tg_valid && !tg_gc && last_cmd_r == gc_operate |-> tg_len == 8'h04;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("run telegram not full");
endmodule : fbm_master_ctrl_monitor
`default_nettype wire

// >>> verification/fbm_slave_model.sv
// behavioural slave stations facing the telegram stream
`timescale 1ns/1ns
`default_nettype none
module fbm_slave_model
  import fbm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench controls
  input wire logic slow,
  input wire logic rx_en,
  input wire logic [31:0] rx_base,
  // telegrams
  input wire logic tg_valid,
  output logic tg_ready,
  input wire logic tg_gc,
  input wire fbm_gc_t tg_cmd,
  input wire logic [2:0] tg_slave,
  input wire logic [7:0] tg_len,
  input wire logic [31:0] tg_data,
  // input words
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [2:0] rx_slave,
  output logic [31:0] rx_data
);
  logic [1:0] cnt_r;
  int gc_cnt;
  fbm_gc_t last_cmd;
  logic outs_on;
  logic [7:0] last_len [8];
  logic [31:0] last_data [8];
  wire [2:0] rx_nxt = (rx_slave == 3'h2) ? 3'h0 : rx_slave + 3'h1;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= 2'h0;
      tg_ready <= 1'b0;
      gc_cnt <= 0;
      last_cmd <= gc_clear;
      outs_on <= 1'b0;
      rx_valid <= 1'b0;
      rx_slave <= 3'h0;
      rx_data <= 32'h0000_0000;
    end
    else
    begin
      cnt_r <= cnt_r + 2'h1;
      tg_ready <= !slow || cnt_r == 2'h0;
      if (tg_valid && tg_ready && tg_gc)
      begin
        gc_cnt <= gc_cnt + 1;
        last_cmd <= tg_cmd;
        outs_on <= (tg_cmd == gc_operate);
        // stale entries must not pass for telegrams of the new state
        last_len <= '{default: 8'hEE};
        last_data <= '{default: 32'hEEEE_EEEE};
      end
      else if (tg_valid && tg_ready)
      begin
        last_len[tg_slave] <= tg_len;
        last_data[tg_slave] <= tg_data;
      end
      if (!rx_valid || rx_ready)
      begin
        rx_valid <= rx_en;
        rx_slave <= rx_nxt;
        rx_data <= rx_en ? rx_base + {29'h0, rx_nxt} : ~rx_data;
      end
    end
  end
endmodule : fbm_slave_model
`default_nettype wire

// >>> verification/tb_fieldbus_master_state_control.sv
// self-checking bench of the fieldbus master run-state control
`timescale 1ns/1ns
`default_nettype none
module tb_fieldbus_master_state_control
  import fbm_pkg::*;
;
  logic aclk = 0;
  logic aresetn = 0;
  logic aclken = 1;
  logic cpu_run = 0;
  logic slow = 0;
  logic rx_en = 0;
  logic [31:0] rx_base = 32'hA5A5_0000;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, tg_data, rx_data;
  logic tg_valid, tg_ready, tg_gc, rx_valid, rx_ready;
  fbm_gc_t tg_cmd;
  logic [2:0] tg_slave, rx_slave;
  logic [7:0] tg_len;
  logic master_online_indicator, data_exchange_indicator;
  logic [6:0] station_addr;
  int n_fail = 0;
  int checks_done = 0;
  int c;
  int k;
  initial forever #50 aclk = ~aclk;
  fbm_master_ctrl fbm_master_ctrl_inst (.aclk, .aresetn, .aclken, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_run, .tg_valid, .tg_ready, .tg_gc,
    .tg_cmd, .tg_slave, .tg_len, .tg_data, .rx_valid, .rx_ready, .rx_slave, .rx_data,
    .master_online_indicator, .data_exchange_indicator, .station_addr);
  fbm_slave_model fbm_slave_model_inst (.aclk, .aresetn, .slow, .rx_en, .rx_base,
    .tg_valid, .tg_ready, .tg_gc, .tg_cmd, .tg_slave, .tg_len, .tg_data, .rx_valid,
    .rx_ready, .rx_slave, .rx_data);
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task bound(input int i);
    if (i >= 200)
    begin
      n_fail++;
      finish_test();
    end
  endtask : bound
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
    input logic [3:0] s = 4'hF);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    bound(i);
    chk(s_axi_bresp, r);
    // let the released bready settle before the next request raises it again
    @(posedge aclk);
  endtask : axw
  task axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
    input logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    bound(i);
    chk(s_axi_rdata & m, d);
    chk(s_axi_rresp, r);
    @(posedge aclk);
  endtask : axr
  task wait_gc;
    int i;
    c = fbm_slave_model_inst.gc_cnt;
    for (i = 0; i < 200 && fbm_slave_model_inst.gc_cnt == c; i++)
      @(posedge aclk);
    bound(i);
    repeat (60) @(posedge aclk);
  endtask : wait_gc
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk(master_online_indicator, 0);
    chk(data_exchange_indicator, 0);
    axr(8'h04, 32'hFFFF_FFFF, 32'h0000_0000, 2'h0);
    $display("test power-on done");
    axw(8'h08, 32'h0000_0015, 2'h0);
    axw(8'h0C, 32'h0000_0003, 2'h0);
    axw(8'h10, 32'h0000_0002, 2'h0);
    for (k = 0; k < 3; k++)
      axw(8'h40 + 8'(4 * k), 32'h1234_0000 + k, 2'h0);
    axw(8'h00, 32'h0000_0001, 2'h0);
    repeat (2) @(posedge aclk);
    chk(master_online_indicator, 1);
    chk(station_addr, 7'h15);
    chk(data_exchange_indicator, 0);
    axr(8'h04, 32'h0000_001B, 32'h0000_0009, 2'h0);
    axw(8'h04, 32'h0000_0000, 2'h2);
    axr(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2);
    $display("test online done");
    slow <= 1;
    rx_en <= 1;
    axw(8'h00, 32'h0000_0003, 2'h0);
    wait_gc();
    chk(data_exchange_indicator, 1);
    chk(fbm_slave_model_inst.last_cmd, gc_clear);
    for (k = 0; k < 3; k++)
    begin
      chk(fbm_slave_model_inst.last_len[k], (k == 1) ? 8'h00 : 8'h04);
      chk(fbm_slave_model_inst.last_data[k], 32'h0000_0000);
    end
    axr(8'h88, 32'hFFFF_FFFF, 32'hA5A5_0002, 2'h0);
    $display("test stop done");
    slow <= 0;
    rx_base <= 32'hC3C3_0000;
    cpu_run <= 1;
    wait_gc();
    chk(fbm_slave_model_inst.outs_on, 1);
    for (k = 0; k < 3; k++)
      chk(fbm_slave_model_inst.last_data[k], 32'h1234_0000 + k);
    axw(8'h40, 32'h5555_AAAA, 2'h0);
    repeat (20) @(posedge aclk);
    chk(fbm_slave_model_inst.last_data[0], 32'h5555_AAAA);
    axr(8'h84, 32'hFFFF_FFFF, 32'hC3C3_0001, 2'h0);
    axw(8'h40, 32'hFFFF_9999, 2'h0, 4'h3);
    axr(8'h40, 32'hFFFF_FFFF, 32'h5555_9999, 2'h0);
    $display("test run done");
    aclken <= 0;
    @(posedge aclk);
    c = tg_slave;
    repeat (8) @(posedge aclk);
    chk(tg_slave, c);
    aclken <= 1;
    $display("test freeze done");
    cpu_run <= 0;
    wait_gc();
    chk(fbm_slave_model_inst.outs_on, 0);
    chk(fbm_slave_model_inst.last_data[0], 32'h0000_0000);
    axw(8'h00, 32'h0000_0000, 2'h0);
    repeat (4) @(posedge aclk);
    chk(master_online_indicator, 0);
    chk(data_exchange_indicator, 0);
    axw(8'h00, 32'h0000_0003, 2'h0);
    wait_gc();
    chk(data_exchange_indicator, 1);
    $display("test reload done");
    finish_test();
  end
endmodule : tb_fieldbus_master_state_control
bind fbm_master_ctrl fbm_master_ctrl_monitor #(.DW(DW)) fbm_master_ctrl_monitor_inst (
  .aclk, .aresetn, .cpu_run, .tg_valid, .tg_ready, .tg_gc, .tg_cmd, .tg_slave, .tg_len,
  .tg_data, .master_online_indicator, .data_exchange_indicator);
`default_nettype wire
